// ==== hw/pfpe_consts.svh ====
// Purpose: Offsets, step values, limits and codes of the format engine
// Assumes: Included by every design file that needs a number
// Notes:   Definitions only
`ifndef PFPE_CONSTS_SVH
`define PFPE_CONSTS_SVH

// ***********************************
// Register byte offsets
// ***********************************
`define PFPE_OFS_CMD        12'h000
`define PFPE_OFS_POS        12'h004
`define PFPE_OFS_FMT        12'h008
`define PFPE_OFS_DERIV      12'h00C
`define PFPE_OFS_STAT       12'h010
`define PFPE_OFS_WHEEL      12'h014

// ***********************************
// Command opcodes, CMD[7:0]
// ***********************************
`define PFPE_OP_PRINT       8'h01
`define PFPE_OP_SPACE       8'h02
`define PFPE_OP_BACKSPACE   8'h03
`define PFPE_OP_RETURN      8'h04
`define PFPE_OP_LINEFEED    8'h05
`define PFPE_OP_REV_LF      8'h06
`define PFPE_OP_SET_HSTEP   8'h07
`define PFPE_OP_SET_VSTEP   8'h08
`define PFPE_OP_SET_PAGE    8'h09
`define PFPE_OP_RESTORE_SW  8'h0A
`define PFPE_OP_ENTER_PROP  8'h0B
`define PFPE_OP_EXIT_PROP   8'h0C

// ***********************************
// Pitch switch codes and step values
// ***********************************
`define PFPE_SW_10CPI       2'h0
`define PFPE_SW_12CPI       2'h1
`define PFPE_SW_15CPI       2'h2
`define PFPE_SW_PROP        2'h3
`define PFPE_HSTEP_10CPI    7'h0C
`define PFPE_HSTEP_12CPI    7'h0A
`define PFPE_HSTEP_15CPI    7'h08
`define PFPE_VSTEP_RST      7'h08
`define PFPE_PAGE_RST       7'h42

// ***********************************
// Limits
// ***********************************
`define PFPE_STEP_MAX       7'h7D
`define PFPE_PAGE_MAX       7'h7E
`define PFPE_HPOS_MAX       12'h624
`define PFPE_VPOS_MAX       15'h3D86
`define PFPE_PROP_SPACE     8'h0A
`define PFPE_DIGIT_UNIT     7'h05
`define PFPE_CHAR_BASE      7'h20
`define PFPE_WHEEL_CHARS    96

`endif

// ==== hw/pfpe_pkg.sv ====
// Purpose: Types shared by the format engine files
// Assumes: Numbers live in pfpe_consts.svh
// Notes:   None
package pfpe_pkg;

  typedef enum logic [1:0] {
    PFPE_IDLE,
    PFPE_PRE_MOVE,
    PFPE_STRIKE,
    PFPE_POST_MOVE
  } pfpe_state_type;

  typedef logic [6:0] pfpe_unit_type;

endpackage : pfpe_pkg

// ==== hw/pfpe_wheel_table.sv ====
// Purpose: Proportional unit table per print wheel, with download
// Assumes: Index is character code minus space, 0..95
// Notes:   Downloaded table replaces both built-in tables once loaded
`timescale 1ns/1ps
`include "pfpe_consts.svh"

module pfpe_wheel_table (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   wheel_metal,
  input  wire logic                   dl_we,
  input  wire logic [6:0]             dl_idx,
  input  wire pfpe_pkg::pfpe_unit_type dl_val,
  input  wire logic [6:0]             rd_idx,
  output pfpe_pkg::pfpe_unit_type     rd_unit
);
  import pfpe_pkg::*;

  typedef struct packed {
    logic                                    loaded;
    logic [`PFPE_WHEEL_CHARS-1:0][6:0]       ram;
  } pfpe_tbl_type;

  pfpe_tbl_type q;
  pfpe_tbl_type d;

  // Built-in unit values; digits share one width
  function automatic pfpe_unit_type builtin(input logic [6:0] idx,
                                            input logic       metal);
    logic [6:0] c;
    c = idx + `PFPE_CHAR_BASE;
    if (c >= 7'h30 && c <= 7'h39) begin
      builtin = `PFPE_DIGIT_UNIT;
    end else if (!metal) begin
      builtin = 7'h06;
    end else if (c >= 7'h41 && c <= 7'h5A) begin
      builtin = 7'h06;
    end else if (c >= 7'h61 && c <= 7'h7A) begin
      builtin = 7'h04;
    end else begin
      builtin = 7'h03;
    end
  endfunction : builtin

  always_comb begin
    d = q;
    if (dl_we && dl_idx < 7'(`PFPE_WHEEL_CHARS)) begin
      d.ram[dl_idx] = dl_val;
      d.loaded      = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rd_unit = (q.loaded && rd_idx < 7'(`PFPE_WHEEL_CHARS)) ?
                   q.ram[rd_idx] : builtin(rd_idx, wheel_metal);
endmodule : pfpe_wheel_table

// ==== hw/pfpe_engine.sv ====
// Purpose: Print format and position engine behind an APB slave
// Assumes: pclk 250 MHz; panel pins asynchronous; host bytes decoded
// Notes:   Commands are APB writes to CMD; pready stalls CMD writes while busy
//
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "pfpe_consts.svh"

module pfpe_engine (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [1:0]  pitch_switch,
  input  wire logic        wrap_return_inhibit_jumper,
  input  wire logic        wheel_metal,
  output logic             print_strobe,
  output logic      [6:0]  print_code,
  output logic      [6:0]  ribbon_advance,
  output logic             auto_return
);
  import pfpe_pkg::*;

  typedef struct packed {
    pfpe_state_type st;
    logic [10:0]    hpos;
    logic [13:0]    vpos;
    logic [6:0]     hstep;
    logic [6:0]     vstep;
    logic [6:0]     page_len;
    logic           remote_hmi;
    logic           prop_ovr;
    logic           prop_cmd;
    logic [6:0]     ch;
    logic [7:0]     last_w;
    logic [10:0]    print_pos;
    logic [13:0]    line_num;
    logic [1:0]     sw_a;
    logic [1:0]     sw_b;
    logic           jmp_a;
    logic           jmp_b;
    logic           whl_a;
    logic           whl_b;
    logic           dl_we;
    logic [6:0]     dl_idx;
    logic [6:0]     dl_val;
    logic [31:0]    prdata;
    logic           pready;
    logic           pslverr;
    logic           strobe;
    logic [6:0]     code;
    logic [6:0]     ribbon;
    logic           wrap;
  } pfpe_eng_type;

  pfpe_eng_type  q;
  pfpe_eng_type  d;
  pfpe_unit_type unit;

  // ***********************************
  // Helper functions
  // ***********************************
  function automatic logic [6:0] sw_step(input logic [1:0] sw);
    case (sw)
      `PFPE_SW_10CPI: sw_step = `PFPE_HSTEP_10CPI;
      `PFPE_SW_15CPI: sw_step = `PFPE_HSTEP_15CPI;
      default:        sw_step = `PFPE_HSTEP_12CPI;
    endcase
  endfunction : sw_step

  // Quotient plus one; a zero step yields position one
  function automatic logic [13:0] div_one(input logic [13:0] n,
                                          input logic [6:0]  s);
    if (s == 7'h00) begin
      div_one = 14'h0001;
    end else begin
      div_one = 14'(n / 14'(s)) + 14'h0001;
    end
  endfunction : div_one

  // Forward carriage move, bit 11 flags an automatic return
  function automatic logic [11:0] h_fwd(input logic [10:0] p,
                                        input logic [7:0]  amt,
                                        input logic        inhibit);
    logic [11:0] s;
    s = {1'b0, p} + {4'h0, amt};
    if (s > `PFPE_HPOS_MAX) begin
      if (inhibit) begin
        h_fwd = `PFPE_HPOS_MAX;
      end else begin
        h_fwd = 12'h800;
      end
    end else begin
      h_fwd = s;
    end
  endfunction : h_fwd

  function automatic logic [10:0] h_back(input logic [10:0] p,
                                         input logic [7:0]  amt);
    if ({3'h0, amt} > p) begin
      h_back = 11'h000;
    end else begin
      h_back = p - {3'h0, amt};
    end
  endfunction : h_back

  pfpe_wheel_table u_table (
    .pclk        (pclk),
    .presetn     (presetn),
    .wheel_metal (q.whl_b),
    .dl_we       (q.dl_we),
    .dl_idx      (q.dl_idx),
    .dl_val      (q.dl_val),
    .rd_idx      (q.ch - `PFPE_CHAR_BASE),
    .rd_unit     (unit)
  );

  // ***********************************
  // Next state
  // ***********************************
  always_comb begin
    logic        prop;
    logic        acc;
    logic        wr;
    logic [7:0]  op;
    logic [7:0]  prm;
    logic [11:0] fw;
    logic [14:0] vs;
    d      = q;
    prop   = 1'b0;
    acc    = 1'b0;
    wr     = 1'b0;
    op     = pwdata[7:0];
    prm    = pwdata[15:8];
    fw     = 12'h000;
    vs     = 15'h0000;
    d.sw_a   = pitch_switch;
    d.sw_b   = q.sw_a;
    d.jmp_a  = wrap_return_inhibit_jumper;
    d.jmp_b  = q.jmp_a;
    d.whl_a  = wheel_metal;
    d.whl_b  = q.whl_a;
    d.strobe = 1'b0;
    d.wrap   = 1'b0;
    d.dl_we  = 1'b0;
    d.pready = 1'b0;
    d.pslverr = 1'b0;

    // Host mode commands win; switches count only without host step
    if (q.prop_ovr) begin
      prop = q.prop_cmd;
    end else begin
      prop = !q.remote_hmi && q.sw_b == `PFPE_SW_PROP;
    end
    if (!q.remote_hmi) begin
      d.hstep = sw_step(q.sw_b);
    end

    d.print_pos = 11'(div_one({3'h0, q.hpos}, q.hstep));
    d.line_num  = div_one(q.vpos, q.vstep);

    // ***********************************
    // Character sequencer
    // ***********************************
    case (q.st)
      PFPE_PRE_MOVE: begin
        fw     = h_fwd(q.hpos, {1'b0, unit}, q.jmp_b);
        d.hpos = fw[10:0];
        d.wrap = fw[11];
        d.st   = PFPE_STRIKE;
      end
      PFPE_STRIKE: begin
        d.strobe = 1'b1;
        d.code   = q.ch;
        if (prop) begin
          d.ribbon = unit;
          d.st     = PFPE_POST_MOVE;
        end else begin
          d.ribbon = (q.ch == 7'h20) ? 7'h00 : 7'h06;
          fw       = h_fwd(q.hpos, {1'b0, q.hstep}, q.jmp_b);
          d.hpos   = fw[10:0];
          d.wrap   = fw[11];
          d.last_w = {1'b0, q.hstep};
          d.st     = PFPE_IDLE;
        end
      end
      PFPE_POST_MOVE: begin
        fw       = h_fwd(q.hpos, {1'b0, unit}, q.jmp_b);
        d.hpos   = fw[10:0];
        d.wrap   = fw[11];
        d.last_w = {unit, 1'b0};
        d.st     = PFPE_IDLE;
      end
      default: begin
        d.st = PFPE_IDLE;
      end
    endcase

    // ***********************************
    // APB slave, registered pready, at least one wait state per access
    // ***********************************
    if (psel && penable && !q.pready) begin
      if (!pwrite || paddr != `PFPE_OFS_CMD || q.st == PFPE_IDLE) begin
        d.pready = 1'b1;
      end
      d.prdata = 32'h0000_0000;
      if (paddr == `PFPE_OFS_CMD || paddr == `PFPE_OFS_WHEEL) begin
        d.prdata = 32'h0000_0000;
      end else if (paddr == `PFPE_OFS_POS) begin
        d.prdata = {2'h0, q.vpos, 5'h00, q.hpos};
      end else if (paddr == `PFPE_OFS_FMT) begin
        d.prdata = {9'h000, q.page_len, 1'b0, q.vstep, 1'b0, q.hstep};
      end else if (paddr == `PFPE_OFS_DERIV) begin
        d.prdata = {2'h0, q.line_num, 5'h00, q.print_pos};
      end else if (paddr == `PFPE_OFS_STAT) begin
        d.prdata = {28'h000_0000, q.st != PFPE_IDLE, prop,
                    q.remote_hmi, q.prop_ovr};
      end else begin
        d.pslverr = 1'b1;
      end
    end
    acc = psel && penable && q.pready;
    wr  = acc && pwrite;

    if (wr && paddr == `PFPE_OFS_WHEEL) begin
      d.dl_we  = 1'b1;
      d.dl_idx = pwdata[6:0];
      d.dl_val = pwdata[14:8];
    end

    // ***********************************
    // Command execution
    // ***********************************
    if (wr && paddr == `PFPE_OFS_CMD) begin
      case (op)
        `PFPE_OP_PRINT: begin
          d.ch = prm[6:0];
          if (prop) begin
            d.st = PFPE_PRE_MOVE;
          end else begin
            d.st = PFPE_STRIKE;
          end
        end
        `PFPE_OP_SPACE: begin
          if (prop) begin
            fw       = h_fwd(q.hpos, `PFPE_PROP_SPACE, q.jmp_b);
            d.last_w = `PFPE_PROP_SPACE;
          end else begin
            fw       = h_fwd(q.hpos, {1'b0, q.hstep}, q.jmp_b);
            d.last_w = {1'b0, q.hstep};
          end
          d.hpos = fw[10:0];
          d.wrap = fw[11];
        end
        `PFPE_OP_BACKSPACE: begin
          if (prop) begin
            d.hpos = h_back(q.hpos, q.last_w);
          end else begin
            d.hpos = h_back(q.hpos, {1'b0, q.hstep});
          end
        end
        `PFPE_OP_RETURN: begin
          d.hpos = 11'h000;
        end
        `PFPE_OP_LINEFEED: begin
          vs = {1'b0, q.vpos} + {8'h00, q.vstep};
          if (vs > `PFPE_VPOS_MAX) begin
            d.vpos = 14'(`PFPE_VPOS_MAX);
          end else begin
            d.vpos = vs[13:0];
          end
        end
        `PFPE_OP_REV_LF: begin
          if ({7'h00, q.vstep} > q.vpos) begin
            d.vpos = 14'h0000;
          end else begin
            d.vpos = q.vpos - {7'h00, q.vstep};
          end
        end
        `PFPE_OP_SET_HSTEP: begin
          if (prm != 8'h00 && prm <= {1'b0, `PFPE_STEP_MAX} + 8'h01) begin
            d.hstep      = 7'(prm - 8'h01);
            d.remote_hmi = 1'b1;
          end
        end
        `PFPE_OP_SET_VSTEP: begin
          if (prm != 8'h00 && prm <= {1'b0, `PFPE_STEP_MAX} + 8'h01) begin
            d.vstep = 7'(prm - 8'h01);
          end
        end
        `PFPE_OP_SET_PAGE: begin
          if (prm != 8'h00 && prm <= {1'b0, `PFPE_PAGE_MAX}) begin
            d.page_len = prm[6:0];
          end
        end
        `PFPE_OP_RESTORE_SW: begin
          d.remote_hmi = 1'b0;
          d.prop_ovr   = 1'b0;
        end
        `PFPE_OP_ENTER_PROP: begin
          d.prop_ovr = 1'b1;
          d.prop_cmd = 1'b1;
        end
        `PFPE_OP_EXIT_PROP: begin
          d.prop_ovr = 1'b1;
          d.prop_cmd = 1'b0;
        end
        default: begin
          d.pslverr = 1'b0;
        end
      endcase
    end
  end

  // ***********************************
  // State register
  // ***********************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q          <= '0;
      q.hstep    <= `PFPE_HSTEP_10CPI;
      q.vstep    <= `PFPE_VSTEP_RST;
      q.page_len <= `PFPE_PAGE_RST;
      q.print_pos <= 11'h001;
      q.line_num <= 14'h0001;
    end else begin
      q <= d;
    end
  end

  assign prdata         = q.prdata;
  assign pready         = q.pready;
  assign pslverr        = q.pslverr;
  assign print_strobe   = q.strobe;
  assign print_code     = q.code;
  assign ribbon_advance = q.ribbon;
  assign auto_return    = q.wrap;
endmodule : pfpe_engine

// ==== sim/pfpe_chk_asserts.sv ====
// Purpose: Port level checks of the format engine
// Assumes: Bound to pfpe_engine from the bench top; one clock
// Notes:   Sees only the engine ports
`timescale 1ns/1ps
`include "pfpe_consts.svh"
module pfpe_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [1:0]  pitch_switch,
  input wire logic        wrap_return_inhibit_jumper,
  input wire logic        wheel_metal,
  input wire logic        print_strobe,
  input wire logic [6:0]  print_code,
  input wire logic [6:0]  ribbon_advance,
  input wire logic        auto_return
);
  // ***********************************
  // Properties
  // ***********************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence rd_of(logic [11:0] a);
    pready && !pwrite && paddr == a;
  endsequence
  a_wrap_inhibit: assert property (
    wrap_return_inhibit_jumper [*4] |-> !auto_return)
    else $error("auto return with jumper installed");
  a_wrap_pulse: assert property (auto_return |=> !auto_return)
    else $error("auto return longer than one cycle");
  a_strobe_one: assert property (print_strobe |=> !print_strobe)
    else $error("print strobe longer than one cycle");
  a_ack_bound: assert property ($rose(penable) && psel |-> ##[1:8] pready)
    else $error("access not answered in time");
  a_ack_phase: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
    else $error("error answer not clean");
  a_map_ok: assert property (pready && paddr <= `PFPE_OFS_WHEEL
    && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped register refused");
  a_fmt_range: assert property (rd_of(`PFPE_OFS_FMT) |->
    prdata[6:0] <= `PFPE_STEP_MAX && prdata[14:8] <= `PFPE_STEP_MAX
    && prdata[22:16] != 7'h00 && prdata[22:16] <= `PFPE_PAGE_MAX)
    else $error("format field out of range");
  a_pos_range: assert property (rd_of(`PFPE_OFS_POS) |->
    prdata[10:0] <= `PFPE_HPOS_MAX && prdata[29:16] <= `PFPE_VPOS_MAX)
    else $error("position out of range");
  a_deriv_min: assert property (rd_of(`PFPE_OFS_DERIV) |->
    prdata[10:0] != 11'h000 && prdata[29:16] != 14'h0000)
    else $error("derived number below one");
  c_strobe: cover property (print_strobe);
  c_wrap: cover property (auto_return);
  c_err: cover property (pslverr);
endmodule : pfpe_chk

// ==== sim/pfpe_host.sv ====
// Purpose: Host side bus master issuing commands and reads
// Assumes: Slave ends each access with a one-cycle pready
// Notes:   Step parameters go out biased by one
`timescale 1ns/1ps
`include "pfpe_consts.svh"
module pfpe_host (
  input  wire logic        pclk,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic [31:0] prdata,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
            output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task step_cmd(input logic [7:0] op, input logic [6:0] n);
    logic [31:0] d;
    logic        e;
    xfer(1'b1, `PFPE_OFS_CMD, {16'h0000, {1'b0, n} + 8'h01, op}, d, e);
  endtask : step_cmd
endmodule : pfpe_host

// ==== sim/tb.sv ====
// Purpose: Self checking bench of the format engine
// Assumes: Host model drives the bus; bench drives panel pins
// Notes:   Metal wheel fitted throughout, except for one print in t_wheel
`timescale 1ns/1ps
`include "pfpe_consts.svh"
module tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0]  pitch_switch;
  logic        wrap_return_inhibit_jumper, wheel_metal, print_strobe;
  logic        auto_return;
  logic [6:0]  print_code, ribbon_advance;
  int          failures, tests_run;
  int          strobes, wraps;
  pfpe_engine dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pitch_switch(pitch_switch),
    .wrap_return_inhibit_jumper(wrap_return_inhibit_jumper),
    .wheel_metal(wheel_metal), .print_strobe(print_strobe),
    .print_code(print_code), .ribbon_advance(ribbon_advance),
    .auto_return(auto_return));
  pfpe_host host_u (.pclk(pclk), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata));
  // Strike and wrap pulse counters
  always @(posedge pclk) begin
    if (print_strobe === 1'b1) begin
      strobes++;
    end
    if (auto_return === 1'b1) begin
      wraps++;
    end
  end
  // ***********************************
  // Shared tasks
  // ***********************************
  task give_verdict;
    if (failures == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task rd(input logic [11:0] a, output logic [31:0] d);
    logic e;
    host_u.xfer(1'b0, a, 32'h0000_0000, d, e);
  endtask : rd
  task idle;
    logic [31:0] s;
    do rd(`PFPE_OFS_STAT, s); while (s[3] !== 1'b0);
  endtask : idle
  task cmd(input logic [7:0] op, input logic [7:0] p);
    logic [31:0] d;
    logic        e;
    host_u.xfer(1'b1, `PFPE_OFS_CMD, {16'h0000, p, op}, d, e);
    idle();
  endtask : cmd
  task step(input logic [7:0] op, input logic [6:0] n);
    host_u.step_cmd(op, n);
    idle();
  endtask : step
  task prt(input logic [7:0] c);
    cmd(`PFPE_OP_PRINT, c);
  endtask : prt
  task exp_pos(input logic [10:0] h, input logic [13:0] v);
    logic [31:0] d;
    rd(`PFPE_OFS_POS, d);
    chk("hpos", {21'h0, h}, {21'h0, d[10:0]});
    chk("vpos", {18'h0, v}, {18'h0, d[29:16]});
  endtask : exp_pos
  task exp_reg(input string n, input logic [11:0] a, input logic [31:0] m,
               input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(n, e, d & m);
  endtask : exp_reg
  task set_sw(input logic [1:0] s);
    pitch_switch <= s;
    repeat (3) @(posedge pclk);
  endtask : set_sw
  // ***********************************
  // Scenarios
  // ***********************************
  task t_reset;
    exp_reg("fmt", `PFPE_OFS_FMT, 32'hFFFF_FFFF, 32'h0042_080C);
    exp_pos(0, 0);
    exp_reg("deriv", `PFPE_OFS_DERIV, 32'hFFFF_FFFF, 32'h0001_0001);
  endtask : t_reset
  task t_switch;
    logic [6:0] tbl [4];
    tbl = '{7'd12, 7'd10, 7'd8, 7'd10};
    for (int i = 0; i < 4; i++) begin
      set_sw(i[1:0]);
      exp_reg("hstep", `PFPE_OFS_FMT, 32'h7F,
              {25'h0, tbl[i]});
    end
    exp_reg("prop", `PFPE_OFS_STAT, 32'h4, 32'h4);
    set_sw(2'h0);
  endtask : t_switch
  task t_host_step;
    step(`PFPE_OP_SET_HSTEP, 7'd20);
    set_sw(2'h1);
    exp_reg("hstep", `PFPE_OFS_FMT, 32'h7F, 32'd20);
    step(`PFPE_OP_SET_VSTEP, 7'd5);
    cmd(`PFPE_OP_SET_PAGE, 8'd10);
    cmd(`PFPE_OP_SET_HSTEP, 8'h00);
    exp_reg("hstep", `PFPE_OFS_FMT, 32'h7F, 32'd20);
    cmd(`PFPE_OP_RESTORE_SW, 8'h00);
    exp_reg("fmt", `PFPE_OFS_FMT, 32'hFFFF_FFFF, 32'h000A_050A);
    step(`PFPE_OP_SET_VSTEP, 7'd8);
    cmd(`PFPE_OP_SET_PAGE, 8'd66);
    set_sw(2'h0);
  endtask : t_host_step
  task t_fixed;
    cmd(`PFPE_OP_RETURN, 8'h00);
    prt(8'h41);
    exp_pos(12, 0);
    chk("code", 32'h41, {25'h0, print_code});
    chk("ribbon", 32'd6, {25'h0, ribbon_advance});
    exp_reg("ppos", `PFPE_OFS_DERIV, 32'h7FF, 32'd2);
    cmd(`PFPE_OP_SPACE, 8'h00);
    exp_pos(24, 0);
    cmd(`PFPE_OP_BACKSPACE, 8'h00);
    exp_pos(12, 0);
  endtask : t_fixed
  task t_prop;
    cmd(`PFPE_OP_ENTER_PROP, 8'h00);
    exp_reg("hstep", `PFPE_OFS_FMT, 32'h7F, 32'd12);
    exp_reg("prop", `PFPE_OFS_STAT, 32'h4, 32'h4);
    step(`PFPE_OP_SET_HSTEP, 7'd20);
    cmd(`PFPE_OP_RETURN, 8'h00);
    prt(8'h35);
    exp_pos(10, 0);
    chk("ribbon", 32'd5, {25'h0, ribbon_advance});
    cmd(`PFPE_OP_SPACE, 8'h00);
    exp_pos(20, 0);
    cmd(`PFPE_OP_BACKSPACE, 8'h00);
    exp_pos(10, 0);
    prt(8'h56);
    exp_pos(22, 0);
    cmd(`PFPE_OP_BACKSPACE, 8'h00);
    exp_pos(10, 0);
    cmd(`PFPE_OP_EXIT_PROP, 8'h00);
    prt(8'h56);
    exp_pos(30, 0);
    chk("ribbon", 32'd6, {25'h0, ribbon_advance});
    cmd(`PFPE_OP_RESTORE_SW, 8'h00);
    exp_reg("stat", `PFPE_OFS_STAT, 32'h7, 32'h0);
  endtask : t_prop
  task t_lines;
    cmd(`PFPE_OP_RETURN, 8'h00);
    step(`PFPE_OP_SET_VSTEP, 7'd0);
    cmd(`PFPE_OP_LINEFEED, 8'h00);
    exp_pos(0, 0);
    step(`PFPE_OP_SET_VSTEP, 7'd8);
    cmd(`PFPE_OP_LINEFEED, 8'h00);
    cmd(`PFPE_OP_LINEFEED, 8'h00);
    exp_pos(0, 16);
    exp_reg("deriv", `PFPE_OFS_DERIV, 32'hFFFF_FFFF, 32'h0003_0001);
    cmd(`PFPE_OP_REV_LF, 8'h00);
    exp_pos(0, 8);
  endtask : t_lines
  task t_wrap(input logic jumper, input logic [10:0] h);
    int s0;
    int w0;
    wrap_return_inhibit_jumper <= jumper;
    step(`PFPE_OP_SET_HSTEP, 7'd125);
    cmd(`PFPE_OP_RETURN, 8'h00);
    s0 = strobes;
    w0 = wraps;
    repeat (12) prt(8'h41);
    exp_pos(1500, 8);
    prt(8'h41);
    exp_pos(h, 8);
    chk("strobes", 32'd13, strobes - s0);
    chk("wraps", {31'h0, !jumper}, wraps - w0);
    cmd(`PFPE_OP_RESTORE_SW, 8'h00);
  endtask : t_wrap
  task t_wheel;
    logic [31:0] d;
    logic        e;
    cmd(`PFPE_OP_ENTER_PROP, 8'h00);
    cmd(`PFPE_OP_RETURN, 8'h00);
    prt(8'h61);
    exp_pos(8, 8);
    wheel_metal <= 1'b0;
    repeat (3) @(posedge pclk);
    prt(8'h61);
    exp_pos(20, 8);
    wheel_metal <= 1'b1;
    host_u.xfer(1'b1, `PFPE_OFS_WHEEL, 32'h0000_0715, d, e);
    cmd(`PFPE_OP_RETURN, 8'h00);
    host_u.xfer(1'b1, `PFPE_OFS_CMD, {16'h0000, 8'h35, `PFPE_OP_PRINT}, d, e);
    prt(8'h35);
    exp_pos(28, 8);
    chk("ribbon", 32'd7, {25'h0, ribbon_advance});
    host_u.xfer(1'b0, 12'h018, 32'h0000_0000, d, e);
    chk("slverr", 32'h1, {31'h0, e});
    chk("errdata", 32'h0, d);
  endtask : t_wheel
  // ***********************************
  // Clock, reset, sequence, watchdog
  // ***********************************
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  initial begin
    failures = 0;
    tests_run = 0;
    presetn = 1'b0;
    pitch_switch = 2'h0;
    wrap_return_inhibit_jumper = 1'b0;
    wheel_metal = 1'b1;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    t_reset();
    t_switch();
    t_host_step();
    t_fixed();
    t_prop();
    t_lines();
    t_wrap(1'b0, 11'd0);
    t_wrap(1'b1, 11'd1572);
    t_wheel();
    give_verdict();
  end
  initial begin
    repeat (30000) @(posedge pclk);
    failures++;
    give_verdict();
  end
endmodule : tb
bind pfpe_engine pfpe_chk chk_u (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pitch_switch(pitch_switch),
  .wrap_return_inhibit_jumper(wrap_return_inhibit_jumper),
  .wheel_metal(wheel_metal), .print_strobe(print_strobe),
  .print_code(print_code), .ribbon_advance(ribbon_advance),
  .auto_return(auto_return));
